// [dzc_pkg.sv]
// Shared types and constants for the calibration, termination and refresh link.
package dzc_pkg;
  typedef enum logic [2:0] {CMD_NOP, CMD_MRS, CMD_REF, CMD_PREA, CMD_ACT, CMD_ZQCL, CMD_ZQCS} dzc_cmd_t;
  typedef enum logic [3:0] {OP_ZQCL, OP_ZQCS, OP_REF, OP_SRE, OP_SRX, OP_PDE, OP_PDX, OP_MR0, OP_MR2,
                            OP_ACT} dzc_op_t;
  localparam int CLK_NS = 25;
  localparam int TRFC_NS = 260;
  localparam int TRFC_CYC = (TRFC_NS + CLK_NS - 1) / CLK_NS;
  localparam int TREFI_NS = 7800;
  localparam int TREFI_EXT_NS = 3900;
  localparam int TREFI_CYC = TREFI_NS / CLK_NS;
  localparam int TREFI_EXT_CYC = TREFI_EXT_NS / CLK_NS;
  localparam int CWL_DEF = 5;
  localparam int AL_DEF = 0;
  localparam int TXPDLL_CK_DEF = 10;
  localparam int TCPDED_CK_DEF = 1;
  localparam int TRFC_CK_DEF = 2;
  localparam int ZQINIT_CK_DEF = 512;
  localparam int ZQOPER_CK_DEF = 256;
  localparam int ZQCS_CK_DEF = 64;
  localparam int DIV_DEF = 8;
  localparam int TRP_NS_DEF = 15;
  localparam int TXS_NS_DEF = 270;
  localparam logic [7:0] REG_CFG = 8'h00;
  localparam logic [7:0] REG_CMD = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam int CFG_ODT = 0;
  localparam int CFG_EXT = 1;
  localparam int CFG_ASR = 2;
  localparam int CFG_DLLF = 3;
  localparam int STS_BUSY = 0;
  localparam int STS_CAL = 1;
  localparam int STS_SR = 2;
  localparam int STS_PD = 3;
  localparam int STS_ERR = 4;
  localparam int STS_FIRST = 5;
  localparam int MR0_DLL_BIT = 12;
  localparam int MR2_ASR_BIT = 6;
  localparam int MR2_SRT_BIT = 7;
  localparam logic [2:0] MR_BA0 = 3'h0;
  localparam logic [2:0] MR_BA2 = 3'h2;
  localparam logic MR0_DLLF_RST = 1'b0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage

// [dzc_link_if.sv]
// Link between the memory controller end and the DRAM end.
`timescale 1ns/1ps
interface dzc_link_if;
  import dzc_pkg::*;
  logic ck;
  logic cke;
  logic odt;
  dzc_cmd_t cmd;
  logic [2:0] ba;
  logic [15:0] addr;
  modport ctl (output ck, output cke, output odt, output cmd, output ba, output addr);
  modport dev (input ck, input cke, input odt, input cmd, input ba, input addr);
endinterface

// [dzc_dram_end.sv]
// DRAM end: termination timing around power-down and calibration engine.
`timescale 1ns/1ps
module dzc_dram_end
  import dzc_pkg::*;
#(
  parameter int CWL = CWL_DEF,
  parameter int AL = AL_DEF,
  parameter int TXPDLL_CK = TXPDLL_CK_DEF,
  parameter int TCPDED_CK = TCPDED_CK_DEF,
  parameter int TRFC_CK = TRFC_CK_DEF,
  parameter int ZQINIT_CK = ZQINIT_CK_DEF,
  parameter int ZQOPER_CK = ZQOPER_CK_DEF,
  parameter int ZQCS_CK = ZQCS_CK_DEF
)(
  input wire logic aclk,
  input wire logic aresetn,
  dzc_link_if.dev link,
  input wire logic [7:0] zq_sense,
  output logic rtt_on,
  output logic odt_async,
  output logic trans,
  output logic cal_busy,
  output logic cal_done,
  output logic zq_cur_en,
  output logic srt_ext,
  output logic asr_en,
  output logic [7:0] ron_code,
  output logic [7:0] odt_code
);
  localparam int WL = AL + CWL;
  localparam int ODTLON = WL - 2;
  localparam int ODTLOFF = WL - 2;
  localparam int CW = 12;

  logic ck_s1, ck_s2, ck_s3, cke_s1, cke_s2, odt_s1, odt_s2;
  dzc_cmd_t cmd_s1, cmd_s2;
  logic [2:0] ba_s1, ba_s2;
  logic [15:0] addr_s1, addr_s2;
  logic ck_rise, pd, dll_fast, first_cal, in_window, next_async;
  logic [WL-1:0] odt_pipe;
  logic [7:0] xcnt, ncnt, rcnt;
  logic [CW-1:0] cal_cnt, cal_lim;

  // Every link line passes two flops; the controller changes them half a period
  // before the clock rises, so the synchronised copies are stable at the edge.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ck_s1 <= 1'b0;
      ck_s2 <= 1'b0;
      ck_s3 <= 1'b0;
      cke_s1 <= 1'b0;
      cke_s2 <= 1'b0;
      odt_s1 <= 1'b0;
      odt_s2 <= 1'b0;
      cmd_s1 <= CMD_NOP;
      cmd_s2 <= CMD_NOP;
      ba_s1 <= 3'h0;
      ba_s2 <= 3'h0;
      addr_s1 <= 16'h0000;
      addr_s2 <= 16'h0000;
    end else begin
      ck_s1 <= link.ck;
      ck_s2 <= ck_s1;
      ck_s3 <= ck_s2;
      cke_s1 <= link.cke;
      cke_s2 <= cke_s1;
      odt_s1 <= link.odt;
      odt_s2 <= odt_s1;
      cmd_s1 <= link.cmd;
      cmd_s2 <= cmd_s1;
      ba_s1 <= link.ba;
      ba_s2 <= ba_s1;
      addr_s1 <= link.addr;
      addr_s2 <= addr_s1;
    end
  end

  assign ck_rise = ck_s2 & ~ck_s3;

  // Mode registers: MR0 selects fast or frozen DLL in power-down, MR2 the
  // self-refresh temperature mode.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dll_fast <= MR0_DLLF_RST;
      srt_ext <= 1'b0;
      asr_en <= 1'b0;
    end else if (ck_rise && cmd_s2 == CMD_MRS) begin
      if (ba_s2 == MR_BA0) begin
        dll_fast <= addr_s2[MR0_DLL_BIT];
      end
      if (ba_s2 == MR_BA2) begin
        asr_en <= addr_s2[MR2_ASR_BIT];
        srt_ext <= addr_s2[MR2_SRT_BIT];
      end
    end
  end

  // Power-down tracking. The entry window ends at the later of tCPDED and tRFC
  // after a refresh still running; the exit window lasts tXPDLL clocks.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pd <= 1'b0;
      xcnt <= 8'h00;
      ncnt <= 8'h00;
      rcnt <= 8'h00;
    end else if (ck_rise) begin
      pd <= ~cke_s2;
      if (cmd_s2 == CMD_REF) begin
        rcnt <= 8'(TRFC_CK);
      end else if (rcnt != 8'h00) begin
        rcnt <= rcnt - 8'h01;
      end
      if (pd && cke_s2) begin
        xcnt <= 8'(TXPDLL_CK);
      end else if (xcnt != 8'h00) begin
        xcnt <= xcnt - 8'h01;
      end
      if (!pd && !cke_s2) begin
        ncnt <= (rcnt > 8'(TCPDED_CK)) ? rcnt : 8'(TCPDED_CK);
      end else if (ncnt != 8'h00) begin
        ncnt <= ncnt - 8'h01;
      end
    end
  end

  // The lead of each window, WL-1 clocks before the clock-enable edge, is
  // covered: before exit the part is still in power-down and answers
  // asynchronously, and before entry any change still in the synchronous pipe
  // is answered early, which the wide bounds allow. Windows that overlap keep
  // the answer asynchronous from the first start to the last end.
  assign in_window = (xcnt != 8'h00) | (ncnt != 8'h00);
  assign next_async = ~dll_fast & (pd | in_window);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      odt_async <= 1'b0;
      trans <= 1'b0;
    end else begin
      odt_async <= next_async;
      trans <= ~dll_fast & in_window;
    end
  end

  // Termination. Synchronous mode delays the sampled level by ODTLon or
  // ODTLoff clocks, both carrying the additive latency. Asynchronous mode
  // follows the pin directly with no additive latency; the two-flop input
  // adds about 50 ns, which a real pad would not.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      odt_pipe <= '0;
    end else if (ck_rise) begin
      odt_pipe <= {odt_pipe[WL-2:0], odt_s2};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rtt_on <= 1'b0;
    end else if (odt_async) begin
      rtt_on <= odt_s2;
    end else if (ck_rise) begin
      rtt_on <= rtt_on ? odt_pipe[ODTLOFF-1] : odt_pipe[ODTLON-1];
    end
  end

  // Calibration engine. A command arriving while busy is ignored, since the
  // controller must keep the channel quiet. The results reach the I/O one
  // clock before the window closes; self-refresh exit never starts one.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cal_busy <= 1'b0;
      cal_done <= 1'b0;
      first_cal <= 1'b1;
      cal_cnt <= '0;
      cal_lim <= '0;
      ron_code <= 8'h00;
      odt_code <= 8'h00;
    end else begin
      cal_done <= 1'b0;
      if (ck_rise && !cal_busy && (cmd_s2 == CMD_ZQCL || cmd_s2 == CMD_ZQCS)) begin
        cal_busy <= 1'b1;
        cal_cnt <= '0;
        if (cmd_s2 == CMD_ZQCL) begin
          cal_lim <= first_cal ? CW'(ZQINIT_CK) : CW'(ZQOPER_CK);
          first_cal <= 1'b0;
        end else begin
          cal_lim <= CW'(ZQCS_CK);
        end
      end else if (ck_rise && cal_busy) begin
        cal_cnt <= cal_cnt + CW'(1);
        if (cal_cnt == cal_lim - CW'(2)) begin
          cal_busy <= 1'b0;
          cal_done <= 1'b1;
          ron_code <= zq_sense;
          odt_code <= zq_sense;
        end
      end
    end
  end

  // The reference current only flows while the engine runs.
  assign zq_cur_en = cal_busy;
endmodule

// [dzc_ctl_end.sv]
// Controller end: AXI4-Lite registers, clock divider and command sequencer.
//
// The register offsets and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
module dzc_ctl_end
  import dzc_pkg::*;
#(
  parameter int DIV = DIV_DEF,
  parameter int TRP_NS = TRP_NS_DEF,
  parameter int TXS_NS = TXS_NS_DEF,
  parameter int ZQINIT_CK = ZQINIT_CK_DEF,
  parameter int ZQOPER_CK = ZQOPER_CK_DEF,
  parameter int ZQCS_CK = ZQCS_CK_DEF
)(
  input wire logic aclk,
  input wire logic aresetn,
  dzc_link_if.ctl link,
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp
);
  localparam int HALF = DIV / 2;
  localparam int GW = 16;
  localparam int TRP_CYC = (TRP_NS + CLK_NS - 1) / CLK_NS;
  localparam int TXS_CYC = (TXS_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [1:0] {ST_IDLE, ST_PREA, ST_ISSUE} dzc_state_t;

  dzc_state_t st;
  dzc_op_t cur, pend_op;
  logic [7:0] div_cnt, next_div, wa;
  logic [31:0] wd;
  logic [3:0] ws, cfg;
  logic [GW-1:0] gap, refi;
  logic aw_got, w_got, wr_fire, slot, pend, ref_due, sr, pd, cal_on, first_done, err;
  logic take_ref, take_pend, refuse, cmd_wr, busy;

  function automatic logic mapped(input logic [7:0] a);
    return a == REG_CFG || a == REG_CMD || a == REG_STATUS;
  endfunction

  function automatic logic legal(input dzc_op_t op, input logic in_sr, input logic in_pd);
    if (in_sr) return op == OP_SRX;
    if (in_pd) return op == OP_PDX;
    return op != OP_SRX && op != OP_PDX && op <= OP_ACT;
  endfunction

  // The link clock is this clock divided by DIV; commands change at its fall.
  assign next_div = (div_cnt == 8'(DIV - 1)) ? 8'h00 : div_cnt + 8'h01;
  assign slot = div_cnt == 8'(HALF - 1);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt <= 8'h00;
      link.ck <= 1'b0;
    end else begin
      div_cnt <= next_div;
      link.ck <= next_div < 8'(HALF);
    end
  end

  // Write channel: address and data are taken in either order, one write at a time.
  assign awready = ~aw_got & ~bvalid;
  assign wready = ~w_got & ~bvalid;
  assign wr_fire = aw_got & w_got;
  assign cmd_wr = wr_fire & (wa == REG_CMD) & ws[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      wa <= 8'h00;
      wd <= 32'h0;
      ws <= 4'h0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_got <= 1'b1;
        wa <= awaddr;
      end
      if (wvalid && wready) begin
        w_got <= 1'b1;
        wd <= wdata;
        ws <= wstrb;
      end
      if (wr_fire) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        bvalid <= 1'b1;
        bresp <= mapped(wa) ? RESP_OKAY : RESP_DECERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Read channel answers one cycle after the address is taken.
  assign arready = ~rvalid;
  assign busy = (st != ST_IDLE) | (gap != '0) | pend;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp <= mapped(araddr) ? RESP_OKAY : RESP_DECERR;
      rdata <= 32'h0;
      if (araddr == REG_CFG) rdata <= {28'h0, cfg};
      if (araddr == REG_CMD) rdata <= {27'h0, pend, pend_op};
      if (araddr == REG_STATUS) rdata <= {26'h0, first_done, err, pd, sr, cal_on, busy};
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

  // Configuration and the one-deep order slot; a second order while one waits
  // is refused. A refusal in the same cycle as a clear still sets the flag.
  assign take_ref = (st == ST_IDLE) & (gap == '0) & ref_due & ~sr & ~pd;
  assign take_pend = (st == ST_IDLE) & (gap == '0) & pend & ~take_ref;
  assign refuse = take_pend & ~legal(pend_op, sr, pd);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg <= 4'h0;
      pend <= 1'b0;
      pend_op <= OP_ZQCL;
      err <= 1'b0;
    end else begin
      if (wr_fire && wa == REG_CFG && ws[0]) cfg <= wd[3:0];
      if (take_pend) pend <= 1'b0;
      if (cmd_wr && !(pend && !take_pend)) begin
        pend <= 1'b1;
        pend_op <= dzc_op_t'(wd[3:0]);
      end
      if (wr_fire && wa == REG_STATUS && ws[0] && wd[STS_ERR]) err <= 1'b0;
      if (refuse || (cmd_wr && pend && !take_pend)) err <= 1'b1;
    end
  end

  // Refresh interval timer, halved in the extended temperature range.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      refi <= GW'(TREFI_CYC);
      ref_due <= 1'b0;
    end else begin
      if (take_ref || sr) ref_due <= 1'b0;
      if (refi == '0) begin
        refi <= cfg[CFG_EXT] ? GW'(TREFI_EXT_CYC) : GW'(TREFI_CYC);
        if (!sr) ref_due <= 1'b1;
      end else begin
        refi <= refi - GW'(1);
      end
    end
  end

  // Sequencer. Calibration and refresh go through precharge-all and tRP first.
  // The gap counter blocks every new order, so calibration windows never overlap; after PDX it holds only DIV cycles.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= ST_IDLE;
      cur <= OP_ZQCL;
      gap <= '0;
      sr <= 1'b0;
      pd <= 1'b0;
      cal_on <= 1'b0;
      first_done <= 1'b0;
      link.cke <= 1'b1;
      link.odt <= 1'b0;
      link.cmd <= CMD_NOP;
      link.ba <= 3'h0;
      link.addr <= 16'h0000;
    end else begin
      if (gap != '0) gap <= gap - GW'(1);
      if (gap == GW'(1)) cal_on <= 1'b0;
      if (slot) begin
        link.cmd <= CMD_NOP;
        link.odt <= cfg[CFG_ODT] & ~cal_on;
      end
      unique case (st)
        ST_IDLE: begin
          if (take_ref) begin
            cur <= OP_REF;
            st <= ST_PREA;
          end else if (take_pend && !refuse) begin
            cur <= pend_op;
            st <= (pend_op <= OP_SRE) ? ST_PREA : ST_ISSUE;
          end
        end
        ST_PREA: begin
          if (slot) begin
            link.cmd <= CMD_PREA;
            gap <= GW'(TRP_CYC);
            st <= ST_ISSUE;
          end
        end
        ST_ISSUE: begin
          if (slot && gap == '0) begin
            st <= ST_IDLE;
            gap <= GW'(DIV);
            unique case (cur)
              OP_ZQCL: begin
                link.cmd <= CMD_ZQCL;
                link.odt <= 1'b0;
                cal_on <= 1'b1;
                first_done <= 1'b1;
                gap <= GW'((first_done ? ZQOPER_CK : ZQINIT_CK) * DIV + DIV);
              end
              OP_ZQCS: begin
                link.cmd <= CMD_ZQCS;
                link.odt <= 1'b0;
                cal_on <= 1'b1;
                gap <= GW'(ZQCS_CK * DIV + DIV);
              end
              OP_REF: begin
                link.cmd <= CMD_REF;
                gap <= GW'(TRFC_CYC);
              end
              OP_SRE: begin
                link.cmd <= CMD_REF;
                link.cke <= 1'b0;
                sr <= 1'b1;
              end
              OP_SRX: begin
                link.cke <= 1'b1;
                sr <= 1'b0;
                gap <= GW'(TXS_CYC);
              end
              OP_PDE: begin
                link.cke <= 1'b0;
                pd <= 1'b1;
              end
              OP_PDX: begin
                link.cke <= 1'b1;
                pd <= 1'b0;
              end
              OP_MR0: begin
                link.cmd <= CMD_MRS;
                link.ba <= MR_BA0;
                link.addr <= 16'h0000;
                link.addr[MR0_DLL_BIT] <= cfg[CFG_DLLF];
              end
              OP_MR2: begin
                link.cmd <= CMD_MRS;
                link.ba <= MR_BA2;
                link.addr <= 16'h0000;
                link.addr[MR2_ASR_BIT] <= cfg[CFG_ASR];
                link.addr[MR2_SRT_BIT] <= cfg[CFG_EXT] & ~cfg[CFG_ASR];
              end
              OP_ACT: begin
                link.cmd <= CMD_ACT;
                link.ba <= 3'h0;
              end
              default: begin
                link.cmd <= CMD_NOP;
              end
            endcase
          end
        end
        default: st <= ST_IDLE;
      endcase
    end
  end
endmodule

// [dzc_properties.sv]
// Concurrent checks of the controller-side command rules on the link.
`timescale 1ns/1ps
module dzc_properties
  import dzc_pkg::*;
#(
  parameter int ZQINIT_CK = ZQINIT_CK_DEF,
  parameter int ZQOPER_CK = ZQOPER_CK_DEF,
  parameter int ZQCS_CK = ZQCS_CK_DEF
)(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ck,
  input wire logic cke,
  input wire logic odt,
  input wire dzc_cmd_t cmd,
  input wire logic [2:0] ba,
  input wire logic [15:0] addr
);
  localparam int TXS_CYC = (TXS_NS_DEF + CLK_NS - 1) / CLK_NS;
  logic ck_q;
  logic rise;
  logic zq;
  logic first_done;
  dzc_cmd_t prev_cmd;
  int zq_left;
  int ref_age;
  int cke_age;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Link lines are judged at the aclk edge where ck is first seen high, half a period after they moved.
  assign rise = ck && !ck_q;
  assign zq = rise && (cmd == CMD_ZQCL || cmd == CMD_ZQCS);
  // Quiet ck rises left in the calibration window; only the first long one after reset gets the init time.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ck_q <= 1'b0;
      zq_left <= 0;
      first_done <= 1'b0;
    end else begin
      ck_q <= ck;
      if (zq) begin
        zq_left <= (cmd == CMD_ZQCS) ? ZQCS_CK : (first_done ? ZQOPER_CK : ZQINIT_CK);
        first_done <= first_done | (cmd == CMD_ZQCL);
      end else if (rise && zq_left != 0) begin
        zq_left <= zq_left - 1;
      end
    end
  end
  // Last command and saturating ages of the last refresh and clock-enable rise.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_cmd <= CMD_NOP;
      ref_age <= 1000;
      cke_age <= 1000;
    end else begin
      if (rise) prev_cmd <= cmd;
      ref_age <= (rise && cmd == CMD_REF) ? 0 : (ref_age < 1000 ? ref_age + 1 : ref_age);
      cke_age <= $rose(cke) ? 0 : (cke_age < 1000 ? cke_age + 1 : cke_age);
    end
  end
  property p_zq_quiet;
    rise && zq_left != 0 |-> cmd == CMD_NOP;
  endproperty
  a_zq_quiet: assert property (p_zq_quiet) else $error("command inside calibration window");
  property p_zq_overlap;
    rise && zq_left != 0 |-> !(cmd inside {CMD_ZQCL, CMD_ZQCS});
  endproperty
  a_zq_overlap: assert property (p_zq_overlap) else $error("calibration windows overlap");
  property p_zq_cke;
    zq || zq_left != 0 |-> cke;
  endproperty
  a_zq_cke: assert property (p_zq_cke) else $error("clock enable low during calibration");
  property p_zq_odt;
    (zq || (rise && zq_left != 0)) |-> !odt && cke;
  endproperty
  a_zq_odt: assert property (p_zq_odt) else $error("termination requested during calibration");
  property p_zq_prea;
    zq |-> prev_cmd == CMD_PREA;
  endproperty
  a_zq_prea: assert property (p_zq_prea) else $error("calibration not preceded by precharge");
  property p_ref_gap;
    rise && cmd inside {CMD_REF, CMD_ACT} |-> ref_age >= TRFC_CYC;
  endproperty
  a_ref_gap: assert property (p_ref_gap) else $error("refresh spacing too short");
  property p_srx_gap;
    zq |-> cke_age >= TXS_CYC;
  endproperty
  a_srx_gap: assert property (p_srx_gap) else $error("calibration too soon after clock enable rise");
  property p_mr2_mode;
    rise && cmd == CMD_MRS && ba == MR_BA2 |-> !(addr[MR2_ASR_BIT] && addr[MR2_SRT_BIT]);
  endproperty
  a_mr2_mode: assert property (p_mr2_mode) else $error("both self-refresh modes set");
  c_zqcs: cover property (zq && cmd == CMD_ZQCS);
  c_zqcl_oper: cover property (zq && cmd == CMD_ZQCL && first_done);
  c_ref: cover property (rise && cmd == CMD_REF);
endmodule

// [tb_top.sv]
// Self-checking bench joining the controller end and the DRAM end.
`timescale 1ns/1ps
module tb_top;
  import dzc_pkg::*;
  localparam int D = 8;
  localparam int ZQI = 16;
  localparam int ZQO = 8;
  localparam int ZQS = 4;
  localparam int TXP = 4;
  localparam int ODTL = 5 + 2 - 2;
  localparam int SLO = ODTL * D;
  localparam int SHI = (ODTL + 1) * D + 4;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, zq_sense = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awready, wready, bvalid, arready, rvalid, rtt_on, odt_async, trans, cal_busy, cal_done, zq_cur_en;
  logic srt_ext, asr_en;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [7:0] ron_code, odt_code;
  int errors = 0;
  int checks_done = 0;
  int cycles = 0;
  dzc_link_if dzc_link_if_i ();
  dzc_ctl_end #(.DIV(D), .ZQINIT_CK(ZQI), .ZQOPER_CK(ZQO), .ZQCS_CK(ZQS)) dzc_ctl_end_i (
    .aclk(aclk), .aresetn(aresetn), .link(dzc_link_if_i), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hf), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp));
  dzc_dram_end #(.CWL(5), .AL(2), .TXPDLL_CK(TXP), .ZQINIT_CK(ZQI), .ZQOPER_CK(ZQO), .ZQCS_CK(ZQS)) dzc_dram_end_i (
    .aclk(aclk), .aresetn(aresetn), .link(dzc_link_if_i), .zq_sense(zq_sense), .rtt_on(rtt_on),
    .odt_async(odt_async), .trans(trans), .cal_busy(cal_busy), .cal_done(cal_done), .zq_cur_en(zq_cur_en),
    .srt_ext(srt_ext), .asr_en(asr_en), .ron_code(ron_code), .odt_code(odt_code));
  dzc_properties #(.ZQINIT_CK(ZQI), .ZQOPER_CK(ZQO), .ZQCS_CK(ZQS)) dzc_properties_i (
    .aclk(aclk), .aresetn(aresetn), .ck(dzc_link_if_i.ck), .cke(dzc_link_if_i.cke), .odt(dzc_link_if_i.odt),
    .cmd(dzc_link_if_i.cmd), .ba(dzc_link_if_i.ba), .addr(dzc_link_if_i.addr));
  // Free-running 40 MHz clock.
  initial begin
    forever #12.5 aclk = ~aclk;
  end
  task automatic give_verdict;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Hang guard, far above the few thousand cycles the sequence needs.
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      errors++;
      give_verdict();
    end
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic cmp_rng(input int v, input int lo, input int hi, input string m);
    checks_done++;
    if (v < lo || v > hi) begin
      errors++;
      $display("[FAIL] %0t %s %0d outside %0d..%0d", $time, m, v, lo, hi);
    end
  endtask
  // Address and data go out together; each is dropped once taken, bready stays up until the response.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    cmp(bresp, er, "write response");
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  // Polling status rather than waiting fixed cycles, since auto refresh may delay an order.
  task automatic order(input logic [3:0] op);
    logic [31:0] s;
    logic [1:0] r;
    axi_wr(REG_CMD, {28'h0, op}, RESP_OKAY);
    do axi_rd(REG_STATUS, s, r); while (s[STS_BUSY] || s[STS_CAL]);
  endtask
  task automatic zq_run(input logic [3:0] op, input int w);
    int n;
    logic [31:0] s;
    logic [1:0] r;
    n = 0;
    zq_sense <= 8'($urandom);
    axi_wr(REG_CMD, {28'h0, op}, RESP_OKAY);
    while (!cal_done) begin
      @(posedge aclk);
      n += int'(cal_busy);
    end
    cmp_rng(n, (w - 2) * D, w * D, "calibration window");
    repeat (2) @(posedge aclk);
    cmp({ron_code, odt_code}, {zq_sense, zq_sense}, "codes transferred");
    cmp(zq_cur_en, 1'b0, "calibration current off");
    // Wait for the controller's own window to close before the next order.
    do axi_rd(REG_STATUS, s, r); while (s[STS_BUSY] || s[STS_CAL]);
  endtask
  task automatic odt_lat(input logic v, input int lo, input int hi);
    int n;
    n = 0;
    axi_wr(REG_CFG, {31'h0, v}, RESP_OKAY);
    while (dzc_link_if_i.odt !== v) @(posedge aclk);
    while (rtt_on !== v) begin
      @(posedge aclk);
      n++;
    end
    cmp_rng(n, lo, hi, "odt to termination");
  endtask
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [7:0] keep;
    int n;
    void'($urandom(32'hc100));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(REG_CFG, d, r);
    cmp(d, 32'h0, "config reset");
    axi_rd(REG_STATUS, d, r);
    cmp(d, 32'h0, "status reset");
    cmp({ron_code, odt_code, rtt_on}, 17'h0, "device reset");
    n = $urandom_range(3, 63);
    axi_rd(8'(n * 4), d, r);
    cmp({d[29:0], r}, {30'h0, RESP_DECERR}, "unmapped read");
    axi_wr(8'(n * 4), $urandom, RESP_DECERR);
    // First long run gets the init window, the next the operating one, then a short one.
    for (int i = 0; i < 3; i++) zq_run(4'(i / 2), i == 0 ? ZQI : (i == 1 ? ZQO : ZQS));
    axi_rd(REG_STATUS, d, r);
    cmp(d[STS_FIRST], 1'b1, "first long calibration flag");
    keep = ron_code;
    order(4'h3);
    zq_sense <= ~keep;
    order(4'h4);
    repeat (4 * D) @(posedge aclk);
    cmp({cal_busy, ron_code}, {1'b0, keep}, "no calibration after self-refresh");
    zq_run(4'h1, ZQS);
    odt_lat(1'b1, SLO, SHI);
    odt_lat(1'b0, SLO, SHI);
    order(4'h7);
    order(4'h5);
    cmp(odt_async, 1'b1, "async mode in power-down");
    odt_lat(1'b1, 0, 6);
    odt_lat(1'b0, 0, 6);
    axi_wr(REG_CMD, 32'h6, RESP_OKAY);
    n = 0;
    while (!trans) @(posedge aclk);
    while (trans) begin
      @(posedge aclk);
      n++;
    end
    cmp_rng(n, (TXP - 1) * D, (TXP + 2) * D, "exit window");
    cmp(odt_async, 1'b0, "sync mode after exit window");
    odt_lat(1'b1, SLO, SHI);
    odt_lat(1'b0, SLO, SHI);
    // Random self-refresh modes, each followed by a refresh or activate for the spacing checks.
    for (int i = 0; i < 4; i++) begin
      n = $urandom_range(0, 2);
      axi_wr(REG_CFG, {29'h0, n == 1, n == 2, 1'b0}, RESP_OKAY);
      order(4'h8);
      cmp({srt_ext, asr_en}, {n == 2, n == 1}, "self-refresh mode");
      order($urandom_range(0, 1) ? 4'h2 : 4'h9);
    end
    // Spacing of the second and third auto refresh after the switch, when the timer has surely reloaded short.
    axi_wr(REG_CFG, 32'h1 << CFG_EXT, RESP_OKAY);
    repeat (2) begin
      while (dzc_link_if_i.cmd != CMD_REF) @(posedge aclk);
      while (dzc_link_if_i.cmd == CMD_REF) @(posedge aclk);
    end
    n = 0;
    while (dzc_link_if_i.cmd != CMD_REF) begin
      @(posedge aclk);
      n++;
    end
    cmp_rng(n + D, TREFI_EXT_CYC - D, TREFI_EXT_CYC + D, "extended refresh interval");
    // Polled order, since an auto refresh ahead of it delays the refusal.
    order(4'($urandom_range(10, 15)));
    axi_rd(REG_STATUS, d, r);
    cmp(d[STS_ERR], 1'b1, "error flag set");
    axi_wr(REG_STATUS, 32'h1 << STS_ERR, RESP_OKAY);
    axi_rd(REG_STATUS, d, r);
    cmp(d[STS_ERR], 1'b0, "error flag cleared");
    give_verdict();
  end
endmodule
